/* File: include/slr_pkg.sv */
/*
  Constants shared by the serial-link lane configuration register bank:
  register offsets, field positions, reset values and widths.
  Assumes an 8-bit register port with a 12-bit byte address.
*/
package slr_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam int LANE_W = 10;
  localparam int NUM_LANES = 4;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_SAMPLES_PER_FRAME_INFO = 12'h591;
  localparam logic [11:0] ADDR_DENSITY_CTRL_WORD_INFO = 12'h592;
  localparam logic [11:0] ADDR_LANE0_CONFIG_CHECKSUM = 12'h5A0;
  localparam logic [11:0] ADDR_LANE1_CONFIG_CHECKSUM = 12'h5A1;
  localparam logic [11:0] ADDR_LANE2_CONFIG_CHECKSUM = 12'h5A2;
  localparam logic [11:0] ADDR_LANE3_CONFIG_CHECKSUM = 12'h5A3;
  localparam logic [11:0] ADDR_LANE_FORCE_POWERDOWN = 12'h5B0;
  localparam logic [11:0] ADDR_PHYSICAL_LANE0_MAPPING = 12'h5B2;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int SPF_FIELD_MSB = 4;
  localparam int SPF_RSVD_LSB = 5;
  localparam int HD_BIT = 7;
  localparam int CF_FIELD_MSB = 4;
  localparam int PWRDN_LANE0_BIT = 0;
  localparam int PWRDN_BIT_STRIDE = 2;
  localparam int MAP_FIELD_MSB = 2;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [2:0] SPF_RSVD_VALUE = 3'h1;
  localparam logic [4:0] SPF_FIELD_RST = 5'h00;
  localparam logic HD_RST = 1'b0;
  localparam logic [4:0] CF_FIELD_RST = 5'h00;
  localparam logic [3:0][7:0] CHECKSUM_RST = {8'hC6, 8'hC5, 8'hC4, 8'hC3};
  localparam logic [3:0] PWRDN_RST = 4'h0;
  localparam logic [2:0] MAP0_RST = 3'h0;
  localparam logic [9:0] LANE_IDLE = 10'h000;

  // ----------------------------------------------------------------
  // Logical lane codes for the mapping field
  // ----------------------------------------------------------------
  localparam logic [2:0] LOGICAL_LANE0 = 3'h0;
  localparam logic [2:0] LOGICAL_LANE1 = 3'h1;
  localparam logic [2:0] LOGICAL_LANE2 = 3'h2;
  localparam logic [2:0] LOGICAL_LANE3 = 3'h3;

endpackage

/* File: core/slr_lane_checksum.sv */
/*
  Per-lane configuration checksum: sum of all link parameters of one lane,
  wrapped to eight bits.
  Assumes the parameters are stable register values from the same clock domain.
*/
`timescale 1ns/1ps
`default_nettype none

module slr_lane_checksum (
  input wire logic [7:0] dev_id,
  input wire logic [3:0] bank_id,
  input wire logic [4:0] lane_id,
  input wire logic scramble_en,
  input wire logic [4:0] lanes_m1,
  input wire logic [7:0] octets_m1,
  input wire logic [4:0] frames_m1,
  input wire logic [7:0] converters_m1,
  input wire logic [1:0] ctrl_bits,
  input wire logic [4:0] resolution_m1,
  input wire logic [2:0] subclass,
  input wire logic [4:0] bits_per_sample_m1,
  input wire logic [2:0] link_version,
  input wire logic [4:0] samples_m1,
  input wire logic high_density,
  input wire logic [4:0] ctrl_words,
  output logic [7:0] checksum
);

  // ----------------------------------------------------------------
  // Modulo-256 sum
  // ----------------------------------------------------------------
  // Each term is widened to eight bits so the carry out is dropped on purpose
  always_comb begin
    checksum = 8'(dev_id)
             + 8'(bank_id)
             + 8'(lane_id)
             + 8'(scramble_en)
             + 8'(lanes_m1)
             + 8'(octets_m1)
             + 8'(frames_m1)
             + 8'(converters_m1)
             + 8'(ctrl_bits)
             + 8'(resolution_m1)
             + 8'(subclass)
             + 8'(bits_per_sample_m1)
             + 8'(link_version)
             + 8'(samples_m1)
             + 8'(high_density)
             + 8'(ctrl_words);
  end

endmodule

`default_nettype wire

/* File: core/slr_lane_cfg_regs.sv */
/*
  Serial-link lane configuration register bank: frame parameter reporting,
  per-lane configuration checksums, lane force power-down and the logical
  lane that drives physical output lane 0.
  Assumes one clock, link parameters supplied by the rest of the link
  register bank, and a register port whose strobes are one cycle long.
*/
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module slr_lane_cfg_regs (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [11:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [7:0] cfg_dev_id,
  input wire logic [3:0] cfg_bank_id,
  input wire logic [4:0] cfg_lane_id_base,
  input wire logic cfg_scramble_en,
  input wire logic [4:0] cfg_lanes_m1,
  input wire logic [7:0] cfg_octets_m1,
  input wire logic [4:0] cfg_frames_m1,
  input wire logic [7:0] cfg_converters_m1,
  input wire logic [1:0] cfg_ctrl_bits,
  input wire logic [4:0] cfg_resolution_m1,
  input wire logic [2:0] cfg_subclass,
  input wire logic [4:0] cfg_bits_per_sample_m1,
  input wire logic [2:0] cfg_link_version,
  input wire logic [4:0] cfg_samples_m1,
  input wire logic cfg_high_density,
  input wire logic [4:0] cfg_ctrl_words,
  input wire logic [9:0] logical_lane0_data,
  input wire logic [9:0] logical_lane1_data,
  input wire logic [9:0] logical_lane2_data,
  input wire logic [9:0] logical_lane3_data,
  output logic [9:0] serial_out_lane0,
  output logic [9:0] serial_out_lane1,
  output logic [9:0] serial_out_lane2,
  output logic [9:0] serial_out_lane3,
  output logic [3:0] lane_powerdown,
  output logic [2:0] physical_lane0_sel
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [4:0] samples_per_frame_reg;
  logic high_density_reg;
  logic [4:0] ctrl_words_reg;
  logic [7:0] checksum_next [slr_pkg::NUM_LANES];
  logic [7:0] checksum_reg [slr_pkg::NUM_LANES];
  logic [3:0] powerdown_reg;
  logic [3:0] powerdown_next;
  logic [2:0] lane0_map_reg;
  logic [7:0] rdata_next;
  logic [7:0] rdata_reg;
  logic [7:0] samples_info_value;
  logic [7:0] density_info_value;
  logic [7:0] powerdown_value;
  logic [7:0] mapping_value;
  logic [9:0] lane_in [slr_pkg::NUM_LANES];
  logic [2:0] lane_src [slr_pkg::NUM_LANES];
  logic [9:0] lane_next [slr_pkg::NUM_LANES];
  logic [9:0] lane_out_reg [slr_pkg::NUM_LANES];
  logic wr_powerdown;
  logic wr_mapping;

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  // Writes to read-only or unmapped offsets are dropped silently
  assign wr_powerdown = reg_wr && (reg_addr == slr_pkg::ADDR_LANE_FORCE_POWERDOWN);
  assign wr_mapping = reg_wr && (reg_addr == slr_pkg::ADDR_PHYSICAL_LANE0_MAPPING);

  // ----------------------------------------------------------------
  // Frame parameter reporting
  // ----------------------------------------------------------------
  // Tracks the link setup every cycle; software has no write path here
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      samples_per_frame_reg <= slr_pkg::SPF_FIELD_RST;
    end else begin
      samples_per_frame_reg <= cfg_samples_m1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      high_density_reg <= slr_pkg::HD_RST;
      ctrl_words_reg <= slr_pkg::CF_FIELD_RST;
    end else begin
      high_density_reg <= cfg_high_density;
      ctrl_words_reg <= cfg_ctrl_words;
    end
  end

  always_comb begin
    samples_info_value = 8'h00;
    samples_info_value[slr_pkg::SPF_FIELD_MSB:0] = samples_per_frame_reg;
    samples_info_value[7:slr_pkg::SPF_RSVD_LSB] = slr_pkg::SPF_RSVD_VALUE;
  end

  always_comb begin
    density_info_value = 8'h00;
    density_info_value[slr_pkg::HD_BIT] = high_density_reg;
    density_info_value[slr_pkg::CF_FIELD_MSB:0] = ctrl_words_reg;
  end

  // ----------------------------------------------------------------
  // Per-lane configuration checksums
  // ----------------------------------------------------------------
  // Lane identity differs per lane, so each lane sums its own value
  generate
    for (genvar i = 0; i < slr_pkg::NUM_LANES; i++) begin : g_checksum
      slr_lane_checksum u_checksum (
        .dev_id(cfg_dev_id),
        .bank_id(cfg_bank_id),
        .lane_id(5'(cfg_lane_id_base + 5'(i))),
        .scramble_en(cfg_scramble_en),
        .lanes_m1(cfg_lanes_m1),
        .octets_m1(cfg_octets_m1),
        .frames_m1(cfg_frames_m1),
        .converters_m1(cfg_converters_m1),
        .ctrl_bits(cfg_ctrl_bits),
        .resolution_m1(cfg_resolution_m1),
        .subclass(cfg_subclass),
        .bits_per_sample_m1(cfg_bits_per_sample_m1),
        .link_version(cfg_link_version),
        .samples_m1(cfg_samples_m1),
        .high_density(cfg_high_density),
        .ctrl_words(cfg_ctrl_words),
        .checksum(checksum_next[i])
      );

      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          checksum_reg[i] <= slr_pkg::CHECKSUM_RST[i];
        end else begin
          checksum_reg[i] <= checksum_next[i];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Lane force power-down
  // ----------------------------------------------------------------
  // Only the even bits are stored; odd bits stay reserved
  always_comb begin
    powerdown_next = powerdown_reg;
    if (wr_powerdown) begin
      for (int j = 0; j < slr_pkg::NUM_LANES; j++) begin
        powerdown_next[j] = reg_wdata[slr_pkg::PWRDN_LANE0_BIT + slr_pkg::PWRDN_BIT_STRIDE * j];
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      powerdown_reg <= slr_pkg::PWRDN_RST;
    end else begin
      powerdown_reg <= powerdown_next;
    end
  end

  always_comb begin
    powerdown_value = 8'h00;
    for (int j = 0; j < slr_pkg::NUM_LANES; j++) begin
      powerdown_value[slr_pkg::PWRDN_LANE0_BIT + slr_pkg::PWRDN_BIT_STRIDE * j] = powerdown_reg[j];
    end
  end

  // ----------------------------------------------------------------
  // Physical lane 0 mapping
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lane0_map_reg <= slr_pkg::MAP0_RST;
    end else if (wr_mapping) begin
      lane0_map_reg <= reg_wdata[slr_pkg::MAP_FIELD_MSB:0];
    end
  end

  always_comb begin
    mapping_value = 8'h00;
    mapping_value[slr_pkg::MAP_FIELD_MSB:0] = lane0_map_reg;
  end

  // ----------------------------------------------------------------
  // Lane data path
  // ----------------------------------------------------------------
  assign lane_in[0] = logical_lane0_data;
  assign lane_in[1] = logical_lane1_data;
  assign lane_in[2] = logical_lane2_data;
  assign lane_in[3] = logical_lane3_data;

  // Physical lane 0 follows the mapping field; the others keep their own lane
  assign lane_src[0] = lane0_map_reg;
  assign lane_src[1] = slr_pkg::LOGICAL_LANE1;
  assign lane_src[2] = slr_pkg::LOGICAL_LANE2;
  assign lane_src[3] = slr_pkg::LOGICAL_LANE3;

  generate
    for (genvar i = 0; i < slr_pkg::NUM_LANES; i++) begin : g_lane
      // Codes above logical lane 3 and powered-down lanes send idle
      always_comb begin
        lane_next[i] = slr_pkg::LANE_IDLE;
        if (!powerdown_reg[i]) begin
          case (lane_src[i])
            slr_pkg::LOGICAL_LANE0: begin
              lane_next[i] = lane_in[0];
            end
            slr_pkg::LOGICAL_LANE1: begin
              lane_next[i] = lane_in[1];
            end
            slr_pkg::LOGICAL_LANE2: begin
              lane_next[i] = lane_in[2];
            end
            slr_pkg::LOGICAL_LANE3: begin
              lane_next[i] = lane_in[3];
            end
            default: begin
              lane_next[i] = slr_pkg::LANE_IDLE;
            end
          endcase
        end
      end

      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          lane_out_reg[i] <= slr_pkg::LANE_IDLE;
        end else begin
          lane_out_reg[i] <= lane_next[i];
        end
      end
    end
  endgenerate

  assign serial_out_lane0 = lane_out_reg[0];
  assign serial_out_lane1 = lane_out_reg[1];
  assign serial_out_lane2 = lane_out_reg[2];
  assign serial_out_lane3 = lane_out_reg[3];
  assign lane_powerdown = powerdown_reg;
  assign physical_lane0_sel = lane0_map_reg;

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Unmapped offsets read as zero
  always_comb begin
    rdata_next = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        slr_pkg::ADDR_SAMPLES_PER_FRAME_INFO: begin
          rdata_next = samples_info_value;
        end
        slr_pkg::ADDR_DENSITY_CTRL_WORD_INFO: begin
          rdata_next = density_info_value;
        end
        slr_pkg::ADDR_LANE0_CONFIG_CHECKSUM: begin
          rdata_next = checksum_reg[0];
        end
        slr_pkg::ADDR_LANE1_CONFIG_CHECKSUM: begin
          rdata_next = checksum_reg[1];
        end
        slr_pkg::ADDR_LANE2_CONFIG_CHECKSUM: begin
          rdata_next = checksum_reg[2];
        end
        slr_pkg::ADDR_LANE3_CONFIG_CHECKSUM: begin
          rdata_next = checksum_reg[3];
        end
        slr_pkg::ADDR_LANE_FORCE_POWERDOWN: begin
          rdata_next = powerdown_value;
        end
        slr_pkg::ADDR_PHYSICAL_LANE0_MAPPING: begin
          rdata_next = mapping_value;
        end
        default: begin
          rdata_next = 8'h00;
        end
      endcase
    end
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;

endmodule

`default_nettype wire

/* File: verif/slr_lane_cfg_asserts.sv */
/* Port checker for the lane configuration register bank.
   Bound to slr_lane_cfg_regs; one clock mclk, async reset rst_n. */
`timescale 1ns/1ps
`default_nettype none
module slr_lane_cfg_asserts (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [11:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [9:0] logical_lane1_data,
  input wire logic [9:0] logical_lane3_data,
  input wire logic [9:0] serial_out_lane0,
  input wire logic [9:0] serial_out_lane1,
  input wire logic [3:0] lane_powerdown,
  input wire logic [2:0] physical_lane0_sel
);
  // ----------------
  // Helpers
  // ----------------
  logic is_pd;
  logic is_map;
  logic [7:0] pd_bits;
  assign is_pd = reg_addr == slr_pkg::ADDR_LANE_FORCE_POWERDOWN;
  assign is_map = reg_addr == slr_pkg::ADDR_PHYSICAL_LANE0_MAPPING;
  assign pd_bits = {1'b0, lane_powerdown[3], 1'b0, lane_powerdown[2], 1'b0, lane_powerdown[1], 1'b0, lane_powerdown[0]};
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // ----------------
  // Assertions
  // ----------------
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00) else $error("read data not idle");
  a_pd_write: assert property (reg_wr && is_pd |=> pd_bits == ($past(reg_wdata) & 8'h55))
    else $error("power-down write wrong");
  a_pd_hold: assert property (!(reg_wr && is_pd) |=> $stable(lane_powerdown)) else $error("power-down moved");
  a_map_write: assert property (reg_wr && is_map |=> {5'h00, physical_lane0_sel} == ($past(reg_wdata) & 8'h07))
    else $error("mapping write wrong");
  a_map_hold: assert property (!(reg_wr && is_map) |=> $stable(physical_lane0_sel)) else $error("mapping moved");
  a_pd_read: assert property (reg_rd && is_pd |=> reg_rdata == $past(pd_bits)) else $error("power-down readback");
  a_map_read: assert property (reg_rd && is_map |=> reg_rdata == {5'h00, $past(physical_lane0_sel)})
    else $error("mapping readback");
  a_lane_down: assert property (lane_powerdown[1] |=> serial_out_lane1 == 10'h000) else $error("lane not down");
  a_lane_pass: assert property (!lane_powerdown[1] |=> serial_out_lane1 == $past(logical_lane1_data))
    else $error("lane 1 data wrong");
  a_lane0_map: assert property (!lane_powerdown[0] && physical_lane0_sel == 3'h3 |=>
    serial_out_lane0 == $past(logical_lane3_data)) else $error("lane 0 source wrong");
  c_pd_write: cover property (reg_wr && is_pd);
  c_map3: cover property (!lane_powerdown[0] && physical_lane0_sel == 3'h3);
  c_read: cover property (reg_rd ##1 reg_rdata != 8'h00);
endmodule
bind slr_lane_cfg_regs slr_lane_cfg_asserts i_slr_lane_cfg_asserts (.mclk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata, .logical_lane1_data, .logical_lane3_data, .serial_out_lane0, .serial_out_lane1,
  .lane_powerdown, .physical_lane0_sel);
`default_nettype wire

/* File: verif/slr_lane_rx_model.sv */
/* Receiver-side model of the four physical output lanes.
   Captures every lane word on each rising mclk edge. */
`timescale 1ns/1ps
`default_nettype none
module slr_lane_rx_model (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [9:0] rx_lane0,
  input wire logic [9:0] rx_lane1,
  input wire logic [9:0] rx_lane2,
  input wire logic [9:0] rx_lane3,
  output logic [3:0][9:0] rx_word
);
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rx_word <= '0;
    end else begin
      rx_word <= {rx_lane3, rx_lane2, rx_lane1, rx_lane0};
    end
  end
endmodule
`default_nettype wire

/* File: verif/slr_lane_cfg_regs_tb_top.sv */
/* Self-checking bench for the lane configuration register bank.
   Drives the register port and lane data; a lane receiver model watches the outputs. */
`timescale 1ns/1ps
`default_nettype none
module slr_lane_cfg_regs_tb_top;
  typedef struct packed {
    logic [7:0] dev, oct, conv;
    logic [4:0] base, lanes, frm, res, bps, spf, cf;
    logic [3:0] bank;
    logic [2:0] sub, ver;
    logic [1:0] cs;
    logic scr, hd;
  } slr_tb_cfg_t;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [11:0] reg_addr = 12'h000;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  slr_tb_cfg_t c = '0;
  logic [3:0][9:0] ld = '0;
  logic [3:0][9:0] exp_w;
  logic [3:0][9:0] exp_d;
  logic [3:0][9:0] rx_word;
  logic [9:0] so0, so1, so2, so3;
  logic [3:0] lane_powerdown;
  logic [2:0] physical_lane0_sel;
  logic [7:0] pd_m;
  int map_m;
  logic lane_chk = 1'b0;
  logic [95:0] r;
  int n_mismatch = 0;
  int checked = 0;
  logic [11:0] addrs[8] = '{slr_pkg::ADDR_SAMPLES_PER_FRAME_INFO, slr_pkg::ADDR_DENSITY_CTRL_WORD_INFO,
    slr_pkg::ADDR_LANE0_CONFIG_CHECKSUM, slr_pkg::ADDR_LANE1_CONFIG_CHECKSUM, slr_pkg::ADDR_LANE2_CONFIG_CHECKSUM,
    slr_pkg::ADDR_LANE3_CONFIG_CHECKSUM, slr_pkg::ADDR_LANE_FORCE_POWERDOWN, slr_pkg::ADDR_PHYSICAL_LANE0_MAPPING};

  slr_lane_cfg_regs i_slr_lane_cfg_regs (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cfg_dev_id(c.dev), .cfg_bank_id(c.bank),
    .cfg_lane_id_base(c.base), .cfg_scramble_en(c.scr), .cfg_lanes_m1(c.lanes), .cfg_octets_m1(c.oct),
    .cfg_frames_m1(c.frm), .cfg_converters_m1(c.conv), .cfg_ctrl_bits(c.cs), .cfg_resolution_m1(c.res),
    .cfg_subclass(c.sub), .cfg_bits_per_sample_m1(c.bps), .cfg_link_version(c.ver), .cfg_samples_m1(c.spf),
    .cfg_high_density(c.hd), .cfg_ctrl_words(c.cf), .logical_lane0_data(ld[0]), .logical_lane1_data(ld[1]),
    .logical_lane2_data(ld[2]), .logical_lane3_data(ld[3]), .serial_out_lane0(so0), .serial_out_lane1(so1),
    .serial_out_lane2(so2), .serial_out_lane3(so3), .lane_powerdown(lane_powerdown),
    .physical_lane0_sel(physical_lane0_sel));
  slr_lane_rx_model i_slr_lane_rx_model (.mclk(mclk), .rst_n(rst_n), .rx_lane0(so0), .rx_lane1(so1),
    .rx_lane2(so2), .rx_lane3(so3), .rx_word(rx_word));

  always #5 mclk = ~mclk;

  // ----------------
  // Reference model
  // ----------------
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pd_m <= 8'h00;
      map_m <= 0;
    end else if (reg_wr && reg_addr == addrs[6]) begin
      pd_m <= reg_wdata & 8'h55;
    end else if (reg_wr && reg_addr == addrs[7]) begin
      map_m <= reg_wdata[2:0];
    end
  end

  always @(posedge mclk) begin
    for (int i = 0; i < 4; i++) begin
      ld[i] <= 10'($urandom);
      exp_w[i] <= pd_m[2 * i] ? 10'h000 : (i > 0 ? ld[i] : (map_m < 4 ? ld[map_m] : 10'h000));
    end
    exp_d <= exp_w;
  end

  always @(negedge mclk) begin
    if (lane_chk) begin
      for (int i = 0; i < 4; i++) begin
        chk(rx_word[i], exp_d[i]);
      end
    end
  end

  function automatic int cks(int l);
    return (c.dev + c.bank + ((c.base + l) % 32) + c.scr + c.lanes + c.oct + c.frm + c.conv + c.cs
      + c.res + c.sub + c.bps + c.ver + c.spf + c.hd + c.cf) % 256;
  endfunction

  function automatic logic [7:0] exp_rd(int k);
    case (k)
      0: return {3'h1, c.spf};
      1: return {c.hd, 2'h0, c.cf};
      6: return pd_m;
      7: return 8'(map_m);
      default: return 8'(cks(k - 2));
    endcase
  endfunction

  // ----------------
  // Port tasks
  // ----------------
  task automatic chk(input logic [9:0] s, input logic [9:0] e);
    checked++;
    if (s !== e) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    chk({2'h0, reg_rdata}, {2'h0, e});
  endtask

  task automatic readall();
    for (int k = 0; k < 8; k++) begin
      rd(addrs[k], exp_rd(k));
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ----------------
  // Tests
  // ----------------
  initial begin
    #100us;
    n_mismatch++;
    summarize();
  end

  initial begin
    void'($urandom(32'h4173));
    c.dev = 8'h11;
    repeat (6) @(posedge mclk);
    chk({2'h0, reg_rdata}, 10'h000);
    chk({6'h0, lane_powerdown}, 10'h000);
    chk({7'h0, physical_lane0_sel}, 10'h000);
    rst_n <= 1'b1;
    reg_rd <= 1'b1;
    reg_addr <= slr_pkg::ADDR_LANE0_CONFIG_CHECKSUM;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    chk({2'h0, reg_rdata}, {2'h0, slr_pkg::CHECKSUM_RST[0]});
    repeat (2) @(posedge mclk);
    lane_chk <= 1'b1;
    readall();
    $display("test reset done");
    for (int n = 0; n < 6; n++) begin
      r = {$urandom, $urandom, $urandom};
      @(posedge mclk);
      c <= r[72:0];
      repeat (2) @(posedge mclk);
      readall();
    end
    $display("test checksum done");
    for (int n = 0; n < 8; n++) begin
      wr(addrs[6], n[0] ? 8'h00 : 8'($urandom));
      wr(addrs[7], {5'($urandom), 3'(n)});
      repeat (4) @(posedge mclk);
      readall();
    end
    $display("test lanes done");
    for (int k = 0; k < 6; k++) begin
      wr(addrs[k], 8'($urandom));
    end
    wr(12'h5B1, 8'hFF);
    readall();
    rd(12'h5B1, 8'h00);
    rd(12'h7FF, 8'h00);
    $display("test read-only done");
    summarize();
  end
endmodule
`default_nettype wire
